// [ivp_pkg.sv]
package ivp_pkg;

  // flag and mask layout
  localparam int          NUM_SRC        = 14;
  localparam int          FLAG_W         = 16;
  localparam int          BIT_W          = 4;
  localparam int          BIT_EXT0       = 0;
  localparam int          BIT_EXT1       = 1;
  localparam int          BIT_EXT2       = 2;
  localparam int          BIT_TIMER      = 3;
  localparam int          BIT_SER0_RX    = 4;
  localparam int          BIT_SER0_TX    = 5;
  localparam int          BIT_SER2_RX    = 6;
  localparam int          BIT_SER2_TX    = 7;
  localparam int          BIT_EXT3       = 8;
  localparam int          BIT_HOST       = 9;
  localparam int          BIT_SER1_RX    = 10;
  localparam int          BIT_SER1_TX    = 11;
  localparam int          BIT_DMA4       = 12;
  localparam int          BIT_DMA5       = 13;

  // vector offsets and priorities
  localparam logic [7:0]  OFF_RESET      = 8'h00;
  localparam logic [7:0]  OFF_NMI        = 8'h04;
  localparam logic [7:0]  OFF_TRAP_FIRST = 8'h08;
  localparam logic [7:0]  OFF_TRAP_LAST  = 8'h3c;
  localparam logic [7:0]  OFF_MASK_BASE  = 8'h40;
  localparam logic [7:0]  OFF_RESERVED   = 8'h78;
  localparam logic [4:0]  PRIO_NONE      = 5'h00;
  localparam logic [4:0]  PRIO_RESET     = 5'h01;
  localparam logic [4:0]  PRIO_NMI       = 5'h02;
  localparam logic [4:0]  PRIO_MASK_BASE = 5'h03;

  // software trap numbers
  localparam logic [4:0]  TRAP_NMI       = 5'h10;
  localparam logic [4:0]  TRAP_FIRST     = 5'h11;
  localparam logic [4:0]  TRAP_LAST      = 5'h1e;
  localparam logic [4:0]  TRAP_SLOT_BIAS = 5'h0f;

  // register map, byte addresses
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] REG_FLAGS      = 12'h000;
  localparam logic [11:0] REG_MASK       = 12'h004;
  localparam logic [11:0] REG_CTRL       = 12'h008;
  localparam logic [11:0] REG_VECTOR     = 12'h00c;
  localparam int          CTRL_W         = 2;
  localparam int          CTRL_DMA01     = 0;
  localparam int          CTRL_DMA23     = 1;
  localparam int          VEC_VALID_BIT  = 16;

  // pin slots in the synchroniser
  localparam int          PIN_COUNT      = 6;
  localparam int          PIN_NMI        = 4;
  localparam int          PIN_RST        = 5;

  typedef enum logic [2:0] {KIND_NONE, KIND_RESET, KIND_NMI, KIND_TRAP, KIND_MASKABLE} ivp_kind_t;

endpackage

// [ivp_pin_if.sv]
`timescale 1ns/1ps
interface ivp_pin_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// [ivp_pin_sync.sv]
`timescale 1ns/1ps
module ivp_pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic hclk,
  input wire logic hresetn,
  ivp_pin_if.sync  port
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;

  // three-stage chain; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= IDLE;
      s2_q <= IDLE;
      s3_q <= IDLE;
    end else begin
      s1_q <= port.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only when stages two and three agree, so a single bad sample is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clean_q <= IDLE;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign port.clean = clean_q;

endmodule

// [ivp_top.sv]
`timescale 1ns/1ps
// Summary of operation
// RULE1 - slots four words apart from table base
// RULE2 - reset offset 00 prio 1, nmi 04 prio 2
// RULE3 - software traps 17-30 at 08..3C, no priority
// RULE4 - external pins 0-2 at 40,44,48 prio 3-5
// RULE5 - timer at 4C prio 6, bit 3
// RULE6 - serial0 rx/tx at 50,54, bits 4,5
// RULE7 - bits 6,7 serial2 or dma 0,1
// RULE8 - external pin 3 at 60, bit 8
// RULE9 - host port at 64 prio 12, bit 9
// RULE10 - bits 10,11 serial1 or dma 2,3
// RULE11 - dma 4,5 at 70,74, bits 12,13
// RULE12 - bits 15-14 and offsets 78-7F reserved
// RULE13 - flags and mask share one layout
// RULE14 - external pins 0-2 own bits 0-2
// RULE15 - serial1 tx or dma3 at bit 11
// RULE16 - take flag and mask; lowest number wins
// RULE17 - event sets flag, ack clears, reset/nmi unmasked
module ivp_top (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic                 hw_reset_pin_n,
  input  wire logic                 soft_reset_trap,
  input  wire logic                 nmi_request_n,
  input  wire logic                 ext_request_zero_n,
  input  wire logic                 ext_request_one_n,
  input  wire logic                 ext_request_two_n,
  input  wire logic                 ext_request_three_n,
  input  wire logic                 timer_request,
  input  wire logic                 serial0_rx_request,
  input  wire logic                 serial0_tx_request,
  input  wire logic                 serial1_rx_request,
  input  wire logic                 serial1_tx_request,
  input  wire logic                 serial2_rx_request,
  input  wire logic                 serial2_tx_request,
  input  wire logic                 host_port_request,
  input  wire logic                 dma_ch_zero_request,
  input  wire logic                 dma_ch_one_request,
  input  wire logic                 dma_ch_two_request,
  input  wire logic                 dma_ch_three_request,
  input  wire logic                 dma_ch_four_request,
  input  wire logic                 dma_ch_five_request,
  input  wire logic                 soft_trap_valid,
  input  wire logic [4:0]           soft_trap_num,
  input  wire logic                 core_ack,
  output logic                      vec_valid,
  output logic [7:0]                vec_offset,
  output logic [4:0]                vec_prio,
  output logic                      irq
);
  import ivp_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [NUM_SRC-1:0]   flags_q;
  logic [NUM_SRC-1:0]   flags_d;
  logic [NUM_SRC-1:0]   mask_q;
  logic [NUM_SRC-1:0]   take;
  logic [NUM_SRC-1:0]   src_evt;
  logic [NUM_SRC-1:0]   ack_clr;
  logic [NUM_SRC-1:0]   wr_clr;
  logic [CTRL_W-1:0]    ctrl_q;
  logic [PIN_COUNT-1:0] pin_prev_q;
  logic [3:0]           ext_fall;
  logic                 nmi_fall;
  logic                 rst_low;
  logic                 rst_pend_q;
  logic                 nmi_pend_q;
  logic                 trap_pend_q;
  logic [4:0]           trap_num_q;
  logic                 trap_ok;
  logic                 ap_valid_q;
  logic                 ap_write_q;
  logic [ADDR_W-1:0]    ap_addr_q;
  logic                 rd_pend_q;
  logic                 accept;
  logic                 wr_en;
  logic [31:0]          rd_mux;
  logic                 hreadyout_q;
  logic [31:0]          hrdata_q;
  logic                 hresp_q;
  ivp_kind_t            sel_kind_q;
  ivp_kind_t            kind_d;
  logic [BIT_W-1:0]     sel_bit_q;
  logic [BIT_W-1:0]     bit_d;
  logic [7:0]           off_d;
  logic [4:0]           prio_d;
  logic                 vec_valid_q;
  logic [7:0]           vec_offset_q;
  logic [4:0]           vec_prio_q;
  logic                 irq_q;
  logic                 ack_rst;
  logic                 ack_nmi;
  logic                 ack_trap;

  // pins are asynchronous; filtered levels come back through the interface
  ivp_pin_if #(.W(PIN_COUNT)) pins ();
  assign pins.raw = {hw_reset_pin_n, nmi_request_n, ext_request_three_n,
                     ext_request_two_n, ext_request_one_n, ext_request_zero_n};

  ivp_pin_sync #(.W(PIN_COUNT), .IDLE({PIN_COUNT{1'b1}})) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (pins.sync)
  );

  // edge memory for the filtered pins; pins idle high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_q <= '1;
    end else begin
      pin_prev_q <= pins.clean;
    end
  end

  // request pins are active low and count once per falling edge
  assign ext_fall = pin_prev_q[3:0] & ~pins.clean[3:0];
  assign nmi_fall = pin_prev_q[PIN_NMI] & ~pins.clean[PIN_NMI];
  assign rst_low  = ~pins.clean[PIN_RST];

  // source to flag bit map; shared slots follow the control register
  always_comb begin
    src_evt              = '0;
    src_evt[BIT_EXT0]    = ext_fall[0];  // RULE4 RULE14
    src_evt[BIT_EXT1]    = ext_fall[1];  // RULE4 RULE14
    src_evt[BIT_EXT2]    = ext_fall[2];  // RULE4 RULE14
    src_evt[BIT_TIMER]   = timer_request;  // RULE5
    src_evt[BIT_SER0_RX] = serial0_rx_request;  // RULE6
    src_evt[BIT_SER0_TX] = serial0_tx_request;  // RULE6
    src_evt[BIT_SER2_RX] = ctrl_q[CTRL_DMA01] ? dma_ch_zero_request : serial2_rx_request;  // RULE7
    src_evt[BIT_SER2_TX] = ctrl_q[CTRL_DMA01] ? dma_ch_one_request : serial2_tx_request;  // RULE7
    src_evt[BIT_EXT3]    = ext_fall[3];  // RULE8
    src_evt[BIT_HOST]    = host_port_request;  // RULE9
    src_evt[BIT_SER1_RX] = ctrl_q[CTRL_DMA23] ? dma_ch_two_request : serial1_rx_request;  // RULE10
    src_evt[BIT_SER1_TX] = ctrl_q[CTRL_DMA23] ? dma_ch_three_request : serial1_tx_request;  // RULE10 RULE15
    src_evt[BIT_DMA4]    = dma_ch_four_request;  // RULE11
    src_evt[BIT_DMA5]    = dma_ch_five_request;  // RULE11
  end

  // address phase capture; a read gets one wait state so it sees a write just before it
  assign accept = hready & hsel & htrans[1];
  assign wr_en  = ap_valid_q & ap_write_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= '0;
    end else if (hready) begin
      ap_valid_q <= accept;
      ap_write_q <= hwrite;
      ap_addr_q  <= haddr[ADDR_W-1:0];
    end
  end

  // read data word; reserved and unmapped bits read zero
  always_comb begin
    rd_mux = '0;
    case (ap_addr_q)
      REG_FLAGS:  rd_mux = 32'({2'b00, flags_q});  // RULE12
      REG_MASK:   rd_mux = 32'({2'b00, mask_q});   // RULE12
      REG_CTRL:   rd_mux = 32'(ctrl_q);
      REG_VECTOR: rd_mux = 32'({vec_valid_q, 3'b000, vec_prio_q, vec_offset_q});
      default:    rd_mux = '0;
    endcase
  end

  // bus answer: writes finish at once, reads after one wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      rd_pend_q   <= 1'b0;
      hrdata_q    <= '0;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= !(accept && !hwrite);
      rd_pend_q   <= accept & ~hwrite;
      hresp_q     <= 1'b0;
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // acknowledge decode against what the core is being shown
  assign ack_rst  = core_ack & vec_valid_q & (sel_kind_q == KIND_RESET);
  assign ack_nmi  = core_ack & vec_valid_q & (sel_kind_q == KIND_NMI);
  assign ack_trap = core_ack & vec_valid_q & (sel_kind_q == KIND_TRAP);
  assign ack_clr  = (core_ack && vec_valid_q && sel_kind_q == KIND_MASKABLE) ?
                    NUM_SRC'(1) << sel_bit_q : '0;  // RULE17
  assign wr_clr   = (wr_en && ap_addr_q == REG_FLAGS) ? hwdata[NUM_SRC-1:0] : '0;

  // set beats clear so an event landing on the clearing edge survives
  assign flags_d = (flags_q & ~(ack_clr | wr_clr)) | src_evt;  // RULE17 RULE13

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // mask and control are plain read-write words; upper bits dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= '0;
      ctrl_q <= '0;
    end else if (wr_en) begin
      if (ap_addr_q == REG_MASK) begin
        mask_q <= hwdata[NUM_SRC-1:0];  // RULE13
      end
      if (ap_addr_q == REG_CTRL) begin
        ctrl_q <= hwdata[CTRL_W-1:0];
      end
    end
  end

  // reset and nmi never see the mask; reset is pending out of reset itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_pend_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      rst_pend_q <= (rst_pend_q & ~ack_rst) | rst_low | soft_reset_trap;  // RULE17
      nmi_pend_q <= (nmi_pend_q & ~ack_nmi) | nmi_fall |
                    (soft_trap_valid && soft_trap_num == TRAP_NMI);  // RULE17
    end
  end

  // one software trap is held at a time; a trap while one waits is dropped unless it comes in the cycle of that trap's ack
  assign trap_ok = soft_trap_valid && soft_trap_num >= TRAP_FIRST && soft_trap_num <= TRAP_LAST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_pend_q <= 1'b0;
      trap_num_q  <= '0;
    end else if (trap_ok && (!trap_pend_q || ack_trap)) begin
      trap_pend_q <= 1'b1;  // RULE3
      trap_num_q  <= soft_trap_num;
    end else if (ack_trap) begin
      trap_pend_q <= 1'b0;
    end
  end

  // pick the vector: reset, nmi, trap, then lowest enabled flag bit
  assign take = flags_q & mask_q;  // RULE16

  always_comb begin
    kind_d = KIND_NONE;
    bit_d  = '0;
    off_d  = OFF_RESET;
    prio_d = PRIO_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (take[i]) begin
        bit_d = BIT_W'(i);  // RULE16
      end
    end
    if (rst_pend_q) begin
      kind_d = KIND_RESET;
      off_d  = OFF_RESET;  // RULE2
      prio_d = PRIO_RESET;
    end else if (nmi_pend_q) begin
      kind_d = KIND_NMI;
      off_d  = OFF_NMI;  // RULE2
      prio_d = PRIO_NMI;
    end else if (trap_pend_q) begin
      kind_d = KIND_TRAP;
      off_d  = 8'({trap_num_q - TRAP_SLOT_BIAS, 2'b00});  // RULE1 RULE3
      prio_d = PRIO_NONE;
    end else if (|take) begin
      kind_d = KIND_MASKABLE;
      off_d  = OFF_MASK_BASE + 8'({bit_d, 2'b00});  // RULE1
      prio_d = PRIO_MASK_BASE + 5'(bit_d);
    end
  end

  // presented vector; drops for one cycle after an ack so a stale vector is never re-taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_kind_q   <= KIND_NONE;
      sel_bit_q    <= '0;
      vec_valid_q  <= 1'b0;
      vec_offset_q <= OFF_RESET;
      vec_prio_q   <= PRIO_NONE;
    end else if (core_ack) begin
      sel_kind_q  <= KIND_NONE;
      vec_valid_q <= 1'b0;
    end else begin
      sel_kind_q   <= kind_d;
      sel_bit_q    <= bit_d;
      vec_valid_q  <= (kind_d != KIND_NONE);
      vec_offset_q <= off_d;
      vec_prio_q   <= prio_d;
    end
  end

  // level interrupt while any enabled flag stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |take;
    end
  end

  assign hreadyout  = hreadyout_q;
  assign hrdata     = hrdata_q;
  assign hresp      = hresp_q;
  assign vec_valid  = vec_valid_q;
  assign vec_offset = vec_offset_q;
  assign vec_prio   = vec_prio_q;
  assign irq        = irq_q;

  // checks on vector choice and flag behaviour
  a_reset_vector_first: assert property (  // RULE2
    rst_pend_q && !core_ack |=> vec_valid_q && vec_offset_q == OFF_RESET && vec_prio_q == PRIO_RESET)
    else $error("reset vector not presented");
  a_nmi_vector_next: assert property (  // RULE2
    nmi_pend_q && !rst_pend_q && !core_ack |=> vec_offset_q == OFF_NMI && vec_prio_q == PRIO_NMI)
    else $error("nmi vector wrong");
  a_trap_slot_window: assert property (  // RULE3
    vec_valid_q && sel_kind_q == KIND_TRAP |->
      vec_offset_q >= OFF_TRAP_FIRST && vec_offset_q <= OFF_TRAP_LAST && vec_prio_q == PRIO_NONE)
    else $error("trap vector outside its window");
  a_slot_spacing: assert property (  // RULE1
    vec_valid_q && sel_kind_q == KIND_MASKABLE |->
      vec_offset_q == OFF_MASK_BASE + 8'({sel_bit_q, 2'b00}) && vec_prio_q == PRIO_MASK_BASE + 5'(sel_bit_q))
    else $error("maskable offset or priority off slot");
  a_mask_gate_order: assert property (  // RULE16
    vec_valid_q && sel_kind_q == KIND_MASKABLE |->
      ($past(take) & (NUM_SRC'(1) << sel_bit_q)) != '0 &&
      ($past(take) & ((NUM_SRC'(1) << sel_bit_q) - NUM_SRC'(1))) == '0)
    else $error("maskable vector not the enabled lowest");
  a_timer_flag_set: assert property (  // RULE5
    timer_request |=> flags_q[BIT_TIMER])
    else $error("timer flag not set");
  a_ext_zero_flag: assert property (  // RULE14
    ext_fall[0] |=> flags_q[BIT_EXT0])
    else $error("external zero flag not set");
  a_shared_slot_dma: assert property (  // RULE7
    dma_ch_zero_request && ctrl_q[CTRL_DMA01] |=> flags_q[BIT_SER2_RX])
    else $error("dma zero did not reach shared bit");
  a_ack_clears_flag: assert property (  // RULE17
    core_ack && vec_valid_q && sel_kind_q == KIND_MASKABLE && sel_bit_q == BIT_W'(BIT_TIMER) && !timer_request
      |=> !flags_q[BIT_TIMER] && !vec_valid_q)
    else $error("ack did not clear flag");
  a_reserved_offsets: assert property (  // RULE12
    vec_valid_q |-> vec_offset_q < OFF_RESERVED)
    else $error("reserved vector offset used");
  a_irq_follows_take: assert property (
    irq_q == $past(|take))
    else $error("interrupt output not following enabled flags");
  a_read_wait_state: assert property (
    accept && !hwrite |=> !hreadyout_q ##1 hreadyout_q)
    else $error("read answer timing wrong");

  c_reset_acked:    cover property (vec_valid_q && sel_kind_q == KIND_RESET && core_ack);
  c_maskable_acked: cover property (vec_valid_q && sel_kind_q == KIND_MASKABLE && core_ack);
  c_trap_shown:     cover property (vec_valid_q && sel_kind_q == KIND_TRAP);
  c_flag_read:      cover property (rd_pend_q && ap_addr_q == REG_FLAGS);

endmodule

// [ivp_core_model.sv]
`timescale 1ns/1ps
// processor core stand-in: takes each presented vector after dly cycles
module ivp_core_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        en,
  input  wire logic [1:0]  dly,
  input  wire logic        vec_valid,
  input  wire logic [7:0]  vec_offset,
  input  wire logic [4:0]  vec_prio,
  output logic             core_ack,
  output logic [7:0]       last_off,
  output logic [4:0]       last_prio,
  output logic [15:0]      n_ack
);
  logic [1:0] wait_q;

  // one-cycle ack; dropped at once so the block never sees a second ack
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_ack  <= 1'b0;
      wait_q    <= 2'h0;
      last_off  <= 8'h00;
      last_prio <= 5'h00;
      n_ack     <= 16'h0000;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      wait_q   <= 2'h0;
    end else if (en && vec_valid) begin
      if (wait_q == dly) begin
        core_ack  <= 1'b1;
        last_off  <= vec_offset;
        last_prio <= vec_prio;
        n_ack     <= n_ack + 16'h0001;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// [dsp_interrupt_vector_priority_tb_top.sv]
`timescale 1ns/1ps
module dsp_interrupt_vector_priority_tb_top;
  import ivp_pkg::*;
  typedef struct packed {
    logic [4:0]  src;
    logic [1:0]  ctrl;
    logic [15:0] flags;
    logic [7:0]  off;
    logic [4:0]  prio;
  } ivp_row_t;
  // src index: 0-2 ext, 3 timer, 4-13 flag order, 14-17 dma0-3, 18 nmi, 19 hw reset, 20 soft reset
  ivp_row_t rows [21] = '{
    '{5'h00, 2'h0, 16'h0001, 8'h40, 5'h03}, '{5'h01, 2'h0, 16'h0002, 8'h44, 5'h04},
    '{5'h02, 2'h0, 16'h0004, 8'h48, 5'h05}, '{5'h03, 2'h0, 16'h0008, 8'h4c, 5'h06},
    '{5'h04, 2'h0, 16'h0010, 8'h50, 5'h07}, '{5'h05, 2'h0, 16'h0020, 8'h54, 5'h08},
    '{5'h06, 2'h0, 16'h0040, 8'h58, 5'h09}, '{5'h07, 2'h0, 16'h0080, 8'h5c, 5'h0a},
    '{5'h08, 2'h0, 16'h0100, 8'h60, 5'h0b}, '{5'h09, 2'h0, 16'h0200, 8'h64, 5'h0c},
    '{5'h0a, 2'h0, 16'h0400, 8'h68, 5'h0d}, '{5'h0b, 2'h0, 16'h0800, 8'h6c, 5'h0e},
    '{5'h0c, 2'h0, 16'h1000, 8'h70, 5'h0f}, '{5'h0d, 2'h0, 16'h2000, 8'h74, 5'h10},
    '{5'h0e, 2'h1, 16'h0040, 8'h58, 5'h09}, '{5'h0f, 2'h1, 16'h0080, 8'h5c, 5'h0a},
    '{5'h10, 2'h2, 16'h0400, 8'h68, 5'h0d}, '{5'h11, 2'h2, 16'h0800, 8'h6c, 5'h0e},
    '{5'h12, 2'h0, 16'h0000, 8'h04, 5'h02}, '{5'h13, 2'h0, 16'h0000, 8'h00, 5'h01},
    '{5'h14, 2'h0, 16'h0000, 8'h00, 5'h01}};

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_ack, core_en;
  logic        soft_trap_valid, vec_valid, irq, got;
  logic [1:0]  htrans, dly;
  logic [2:0]  hsize;
  logic [4:0]  soft_trap_num, vec_prio, last_prio;
  logic [7:0]  vec_offset, last_off;
  logic [15:0] n_ack;
  logic [20:0] src_q;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  int          n_fail, cmp_count, cyc;

  assign hready = hreadyout;

  ivp_top ivp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .hw_reset_pin_n(~src_q[19]), .soft_reset_trap(src_q[20]),
    .nmi_request_n(~src_q[18]), .ext_request_zero_n(~src_q[0]), .ext_request_one_n(~src_q[1]),
    .ext_request_two_n(~src_q[2]), .ext_request_three_n(~src_q[8]), .timer_request(src_q[3]),
    .serial0_rx_request(src_q[4]), .serial0_tx_request(src_q[5]), .serial1_rx_request(src_q[10]),
    .serial1_tx_request(src_q[11]), .serial2_rx_request(src_q[6]), .serial2_tx_request(src_q[7]),
    .host_port_request(src_q[9]), .dma_ch_zero_request(src_q[14]), .dma_ch_one_request(src_q[15]),
    .dma_ch_two_request(src_q[16]), .dma_ch_three_request(src_q[17]), .dma_ch_four_request(src_q[12]),
    .dma_ch_five_request(src_q[13]), .soft_trap_valid(soft_trap_valid), .soft_trap_num(soft_trap_num),
    .core_ack(core_ack), .vec_valid(vec_valid), .vec_offset(vec_offset), .vec_prio(vec_prio), .irq(irq));

  ivp_core_model ivp_core_model_i (.hclk(hclk), .hresetn(hresetn), .en(core_en), .dly(dly),
    .vec_valid(vec_valid), .vec_offset(vec_offset), .vec_prio(vec_prio), .core_ack(core_ack),
    .last_off(last_off), .last_prio(last_prio), .n_ack(n_ack));

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer; every change lands right after a rising edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // hold long enough for the pin filter to see the edge, then release
  task pulse(input logic [20:0] bits);
    src_q <= bits;
    repeat (6) @(posedge hclk);
    src_q <= 21'h000000;
    repeat (6) @(posedge hclk);
  endtask

  task wait_ack(output logic ok);
    logic [15:0] k0;
    k0 = n_ack;
    ok = 1'b0;
    for (int k = 0; k < 30 && !ok; k++) begin
      @(posedge hclk);
      ok = (n_ack !== k0);
    end
  endtask

  // clock and a cycle ceiling far above the expected run of under a thousand cycles
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge hclk);
      cyc++;
      if (cyc == 20000) begin
        n_fail++;
        summarize;
      end
    end
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; src_q = 21'h0; soft_trap_valid = 1'b0; soft_trap_num = 5'h00;
    core_en = 1'b0; dly = 2'h0; n_fail = 0; cmp_count = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset vector first, registers clear, unmapped place reads 0
    repeat (2) @(posedge hclk);
    check({15'h0, vec_valid, 3'h0, vec_prio, vec_offset}, 32'h00010100);
    bus(1'b0, REG_FLAGS, 32'h0, rd); check(rd, 32'h0);
    bus(1'b0, REG_MASK, 32'h0, rd); check(rd, 32'h0);
    bus(1'b1, 12'h010, 32'hffffffff, rd);
    bus(1'b0, 12'h010, 32'h0, rd); check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    core_en <= 1'b1;
    wait_ack(got); check(32'(got), 32'h1);
    core_en <= 1'b0;
    $display("test reset done");
    // every source alone, acked after a varying delay
    foreach (rows[i]) begin
      v = {15'h0, 1'b1, 3'h0, rows[i].prio, rows[i].off};
      bus(1'b1, REG_CTRL, {30'h0, rows[i].ctrl}, rd);
      bus(1'b1, REG_MASK, (rows[i].flags != 16'h0) ? 32'hffff : 32'h0, rd);
      pulse(21'h1 << rows[i].src);
      bus(1'b0, REG_FLAGS, 32'h0, rd); check(rd, {16'h0, rows[i].flags});
      bus(1'b0, REG_MASK, 32'h0, rd); check(rd, (rows[i].flags != 16'h0) ? 32'h3fff : 32'h0);
      bus(1'b0, REG_VECTOR, 32'h0, rd); check(rd, v);
      check({15'h0, vec_valid, 3'h0, vec_prio, vec_offset}, v);
      check(32'(irq), 32'(rows[i].flags != 16'h0));
      dly <= i[1:0];
      core_en <= 1'b1;
      wait_ack(got); check({got, last_prio, last_off}, {1'b1, rows[i].prio, rows[i].off});
      core_en <= 1'b0;
      repeat (2) @(posedge hclk);
      bus(1'b0, REG_FLAGS, 32'h0, rd); check(rd, 32'h0);
      check(32'(irq), 32'h0);
    end
    $display("test sources done");
    // masked sources wait; clear by writing one; lowest number goes first
    bus(1'b1, REG_MASK, 32'h0, rd);
    pulse(21'h000208);
    check({30'h0, irq, vec_valid}, 32'h0);
    bus(1'b0, REG_FLAGS, 32'h0, rd); check(rd, 32'h0208);
    bus(1'b1, REG_FLAGS, 32'h8, rd);
    bus(1'b0, REG_FLAGS, 32'h0, rd); check(rd, 32'h0200);
    pulse(21'h000008);
    bus(1'b1, REG_MASK, 32'h0208, rd);
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h1);
    dly <= 2'h0;
    core_en <= 1'b1;
    wait_ack(got); check({got, last_prio, last_off}, {1'b1, 5'h06, 8'h4c});
    wait_ack(got); check({got, last_prio, last_off}, {1'b1, 5'h0c, 8'h64});
    repeat (3) @(posedge hclk);
    check(32'(irq), 32'h0);
    $display("test priority done");
    // software traps 16..30 and one number out of range
    for (int n = 16; n < 32; n++) begin
      soft_trap_valid <= 1'b1;
      soft_trap_num   <= 5'(n);
      @(posedge hclk);
      soft_trap_valid <= 1'b0;
      wait_ack(got);
      check(32'(got), 32'(n < 31));
      if (n < 31) check({last_prio, last_off}, (n == 16) ? {5'h02, 8'h04} : {5'h00, 8'(4 * (n - 15))});
    end
    $display("test traps done");
    // mid-run reset: vector drops while held, mask and control come back cleared
    core_en <= 1'b0;
    bus(1'b1, REG_MASK, 32'h1, rd);
    bus(1'b1, REG_CTRL, 32'h3, rd);
    bus(1'b0, REG_CTRL, 32'h0, rd); check(rd, 32'h3);
    hresetn <= 1'b0;
    @(posedge hclk);
    check({15'h0, vec_valid, 3'h0, vec_prio, vec_offset}, 32'h0);
    check(32'(irq), 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check({15'h0, vec_valid, 3'h0, vec_prio, vec_offset}, 32'h00010100);
    bus(1'b0, REG_MASK, 32'h0, rd); check(rd, 32'h0);
    bus(1'b0, REG_CTRL, 32'h0, rd); check(rd, 32'h0);
    $display("test midrun reset done");
    summarize;
  end
endmodule
